// [hdl/wake_kick_defs.svh]
/*
 * Constants for the wake/kick power sequencer and user-RAM wipe block:
 * register offsets, field positions, reset values and timing figures.
 * Assumes inclusion by bare name from design files under hdl/.
 */
`ifndef WAKE_KICK_DEFS_SVH
`define WAKE_KICK_DEFS_SVH

// ==========================================================================
// Register offsets (bank 1 for the extended ones)
// ==========================================================================
`define OFS_SECONDS_ALARM   7'h01
`define OFS_MINUTES_ALARM   7'h03
`define OFS_HOURS_ALARM     7'h05
`define OFS_DATE_ALARM      7'h49
`define OFS_FLAGS_CONTROL   7'h4A
`define OFS_ENABLE_CONTROL  7'h4B
`define OFS_RAM_LO          7'h0E
`define OFS_RAM_HI          7'h7F
`define OFS_BANK1_LO        7'h40
`define OFS_BANK1_HI        7'h7F

// ==========================================================================
// Field positions
// ==========================================================================
`define BIT_KICK_FLAG       0
`define BIT_WAKE_FLAG       1
`define BIT_WIPE_FLAG       2
`define BIT_POWER_RELEASE   3
`define BIT_FLAGS_SPARE     4
`define BIT_KICK_IRQ_EN     0
`define BIT_WAKE_IRQ_EN     1
`define BIT_WIPE_IRQ_EN     2
`define BIT_HOLD_IN_FAIL    3
`define BIT_WIPE_EN         4

// ==========================================================================
// Reset values, wipe fill byte and divider run field
// ==========================================================================
`define RST_BYTE            8'h00
`define RST_FLAGS           8'h08
`define RAM_ONES            8'hFF
`define DIV_RUN_HI          2'h1

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_PERIOD_NS       10
`define KICK_PULSE_NS       2000
`define POWER_ON_TIMEOUT_S  2
`define NS_PER_S            1000000000
`define WIPE_RECOVERY_NS    1000

`endif

// [hdl/wake_kick_pkg.sv]
/*
 * Types shared by the power sequencer files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package wake_kick_pkg;
  // Power request sequencing states
  typedef enum logic [1:0] {
    PWR_OFF     = 2'b00,
    PWR_WAIT    = 2'b01,
    PWR_ON      = 2'b10
  } pwr_state_t;
endpackage

// [hdl/pulse_qualifier.sv]
/*
 * Synchroniser plus low-level width qualifier for an active-low input.
 * Assumes the input is asynchronous; one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none

module pulse_qualifier #(
  parameter int MIN_CYCLES = 200
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pin_n,
  output logic      fall_pulse,
  output logic      low_ok_pulse,
  output logic      level_n
);
  // ========================================================================
  // Synchroniser: first stage feeds only the second
  // ========================================================================
  logic       meta_ff;
  logic       sync_ff;
  logic       prev_ff;
  logic [15:0] width_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= pin_n;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Width counter saturates so a held low fires once only
  always_ff @(posedge ref_clk) begin
    if (rst || sync_ff) begin
      width_ff <= 16'h0000;
    end else if (width_ff != 16'(MIN_CYCLES)) begin
      width_ff <= width_ff + 16'h0001;
    end
  end

  assign fall_pulse   = prev_ff && !sync_ff;
  assign low_ok_pulse = !sync_ff && (width_ff == 16'(MIN_CYCLES - 1));
  assign level_n      = sync_ff;
endmodule

`default_nettype wire

// [hdl/wake_kick_power.sv]
/*
 * Wake-up / kickstart power request sequencer with user-RAM wipe.
 * Byte-wide register port with chip select, read and write strobes and
 * an access-ready answer; time, date and divider state come from the
 * calendar core outside; supply status comes from the power monitor.
 */
// Operation
// - Wake and kick events act only with oscillator running and divider field 01X.
// - Wake and kick enables gate their features.
// - Full date/hour/minute/second match against alarms is a wake event.
// - Wake matching ignores the ordinary alarm interrupt enable.
// - Wake match drives power request low and sets wake flag.
// - Kick low pulse of 2 us or more requests power, sets kick flag.
// - No supply within 2 s timeout releases request; irq stays off.
// - Flag from failed attempt stays until software clears it.
// - Supply in time keeps request, drives irq, clears power release.
// - Power request holds while power release stays 0.
// - Writing power release 1 releases the request output.
// - Software clears wake and kick flags by writing zeros.
// - When powered, events set flags; enabled flags drive irq.
// - When powered, every enabled wake or kick event asserts power request.
// - Supply below fail threshold floats the irq output.
// - Powered down, request holds if hold-in-fail is 1, else floats.
// - Enabled wipe input fall sets all 114 user RAM bytes to ones.
// - Wipe leaves calendar registers and extended RAM unchanged.
// - Wipe completion sets wipe flag; irq if powered and enabled.
// - Writing 0 to wipe flag clears its interrupt.
// - Accesses are refused for a recovery time after wipe.
// - With wipe disabled the input changes neither RAM nor flag.
// - Power release clears when an enabled wake or kick flag is set.
// - Writing 1 to a flag sets it and drives irq if its enable is set.
`timescale 1ns/10ps
`default_nettype none
`include "wake_kick_defs.svh"

module wake_kick_power #(
  parameter int RAM_BYTES        = 114,
  parameter int POWER_ON_CYCLES  =
    (`POWER_ON_TIMEOUT_S * (`NS_PER_S / `CLK_PERIOD_NS)),
  parameter int KICK_CYCLES      =
    (`KICK_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int RECOVERY_CYCLES  =
    (`WIPE_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       cs,
  input  wire logic       rd,
  input  wire logic       wr,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            access_ready,
  input  wire logic       bank_select,
  input  wire logic [2:0] divider_control,
  input  wire logic       osc_running,
  input  wire logic       supply_valid,
  input  wire logic       other_irq,
  input  wire logic [7:0] cur_seconds,
  input  wire logic [7:0] cur_minutes,
  input  wire logic [7:0] cur_hours,
  input  wire logic [7:0] cur_date,
  input  wire logic       kick_input_n,
  input  wire logic       ram_wipe_input_n,
  output logic            power_request_n_o,
  output logic            power_request_n_oe,
  output logic            irq_n_o,
  output logic            irq_n_oe
);
  // ========================================================================
  // Storage
  // ========================================================================
  logic [7:0] seconds_alarm_ff;
  logic [7:0] minutes_alarm_ff;
  logic [7:0] hours_alarm_ff;
  logic [7:0] date_alarm_ff;
  logic       wake_flag_ff;
  logic       kick_flag_ff;
  logic       ram_wipe_flag_ff;
  logic       power_release_ff;
  logic       spare_ff;
  logic [7:0] enable_ff;
  logic [7:0] ram_ff [RAM_BYTES];
  wake_kick_pkg::pwr_state_t state_ff;
  logic [31:0] timeout_ff;
  logic [15:0] lockout_ff;
  logic       match_prev_ff;
  logic       powered_ff;
  logic [7:0] rdata_ff;

  logic kick_fall;
  logic kick_ok;
  logic wipe_fall;
  logic wipe_level_n;
  logic div_ok;
  logic time_match;
  logic wake_evt;
  logic kick_evt;
  logic wipe_evt;
  logic locked;
  logic wr_en;
  logic rd_en;
  logic [6:0] ram_idx;
  logic in_ram;

  wire logic wake_irq_enable     = enable_ff[`BIT_WAKE_IRQ_EN];
  wire logic kick_irq_enable     = enable_ff[`BIT_KICK_IRQ_EN];
  wire logic ram_wipe_irq_enable = enable_ff[`BIT_WIPE_IRQ_EN];
  wire logic power_hold_in_fail  = enable_ff[`BIT_HOLD_IN_FAIL];
  wire logic ram_wipe_enable     = enable_ff[`BIT_WIPE_EN];

  // Byte address hits user RAM; bank 1 hides the upper part
  function automatic logic ram_hit(input logic [6:0] a, input logic bank);
    ram_hit = (a >= `OFS_RAM_LO) &&
              !(bank && a >= `OFS_BANK1_LO && a <= `OFS_BANK1_HI);
  endfunction

  // ========================================================================
  // Input qualification
  // ========================================================================
  pulse_qualifier #(.MIN_CYCLES(KICK_CYCLES)) kick_q (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .pin_n        (kick_input_n),
    .fall_pulse   (kick_fall),
    .low_ok_pulse (kick_ok),
    .level_n      ()
  );

  pulse_qualifier #(.MIN_CYCLES(1)) wipe_q (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .pin_n        (ram_wipe_input_n),
    .fall_pulse   (wipe_fall),
    .low_ok_pulse (),
    .level_n      (wipe_level_n)
  );

  // ========================================================================
  // Event detection
  // ========================================================================
  // Divider field 01X means oscillator on, chain out of reset
  assign div_ok = osc_running &&
                  (divider_control[2:1] == `DIV_RUN_HI);
  // Alarm-enable of the main control register is not consulted
  assign time_match = (cur_seconds == seconds_alarm_ff) &&
                      (cur_minutes == minutes_alarm_ff) &&
                      (cur_hours   == hours_alarm_ff) &&
                      (cur_date    == date_alarm_ff);
  // Match is edge-detected so a held second yields one event
  assign wake_evt = div_ok && time_match && !match_prev_ff;
  assign kick_evt = div_ok &&
                    (supply_valid ? kick_fall : kick_ok);
  assign wipe_evt = ram_wipe_enable && wipe_fall;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      match_prev_ff <= 1'b0;
    end else begin
      match_prev_ff <= div_ok && time_match;
    end
  end

  // ========================================================================
  // Register port with wipe lockout
  // ========================================================================
  assign locked       = (lockout_ff != 16'h0000) || !wipe_level_n;
  assign access_ready = cs && !locked;
  assign wr_en        = cs && wr && !locked && supply_valid;
  assign rd_en        = cs && rd && !locked;
  assign in_ram       = ram_hit(addr, bank_select);
  assign ram_idx      = addr - `OFS_RAM_LO;

  // Recovery counter starts on the wipe edge whatever the enable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lockout_ff <= 16'h0000;
    end else if (wipe_fall) begin
      lockout_ff <= 16'(RECOVERY_CYCLES);
    end else if (lockout_ff != 16'h0000) begin
      lockout_ff <= lockout_ff - 16'h0001;
    end
  end

  // Alarm and enable registers; seconds/minutes/hours alarms in either bank, date alarm and enable in bank 1 only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seconds_alarm_ff <= `RST_BYTE;
      minutes_alarm_ff <= `RST_BYTE;
      hours_alarm_ff   <= `RST_BYTE;
      date_alarm_ff    <= `RST_BYTE;
      enable_ff        <= `RST_BYTE;
    end else if (wr_en) begin
      if (addr == `OFS_SECONDS_ALARM) begin
        seconds_alarm_ff <= wdata;
      end else if (addr == `OFS_MINUTES_ALARM) begin
        minutes_alarm_ff <= wdata;
      end else if (addr == `OFS_HOURS_ALARM) begin
        hours_alarm_ff <= wdata;
      end else if (bank_select && addr == `OFS_DATE_ALARM) begin
        date_alarm_ff <= wdata;
      end else if (bank_select && addr == `OFS_ENABLE_CONTROL) begin
        enable_ff <= wdata;
      end
    end
  end

  // User RAM: wipe fills with ones; calendar and extended RAM untouched
  always_ff @(posedge ref_clk) begin
    if (wipe_evt) begin
      for (int i = 0; i < RAM_BYTES; i++) begin
        ram_ff[i] <= `RAM_ONES;
      end
    end else if (wr_en && in_ram) begin
      ram_ff[ram_idx] <= wdata;
    end
  end

  // Read mux, registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= `RST_BYTE;
    end else if (rd_en) begin
      if (addr == `OFS_SECONDS_ALARM) begin
        rdata_ff <= seconds_alarm_ff;
      end else if (addr == `OFS_MINUTES_ALARM) begin
        rdata_ff <= minutes_alarm_ff;
      end else if (addr == `OFS_HOURS_ALARM) begin
        rdata_ff <= hours_alarm_ff;
      end else if (bank_select && addr == `OFS_DATE_ALARM) begin
        rdata_ff <= date_alarm_ff;
      end else if (bank_select && addr == `OFS_FLAGS_CONTROL) begin
        rdata_ff <= {3'h0, spare_ff, power_release_ff, ram_wipe_flag_ff,
                     wake_flag_ff, kick_flag_ff};
      end else if (bank_select && addr == `OFS_ENABLE_CONTROL) begin
        rdata_ff <= enable_ff;
      end else if (in_ram) begin
        rdata_ff <= ram_ff[ram_idx];
      end else begin
        rdata_ff <= `RST_BYTE;
      end
    end
  end
  assign rdata = rdata_ff;

  // ========================================================================
  // Flags: hardware set wins over a software clear
  // ========================================================================
  wire logic flags_wr = wr_en && bank_select && addr == `OFS_FLAGS_CONTROL;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_flag_ff     <= 1'b0;
      kick_flag_ff     <= 1'b0;
      ram_wipe_flag_ff <= 1'b0;
      spare_ff         <= 1'b0;
    end else begin
      if (wake_evt) begin
        wake_flag_ff <= 1'b1;
      end else if (flags_wr) begin
        wake_flag_ff <= wdata[`BIT_WAKE_FLAG];
      end
      if (kick_evt) begin
        kick_flag_ff <= 1'b1;
      end else if (flags_wr) begin
        kick_flag_ff <= wdata[`BIT_KICK_FLAG];
      end
      if (wipe_evt) begin
        ram_wipe_flag_ff <= 1'b1;
      end else if (flags_wr) begin
        ram_wipe_flag_ff <= wdata[`BIT_WIPE_FLAG];
      end
      if (flags_wr) begin
        spare_ff <= wdata[`BIT_FLAGS_SPARE];
      end
    end
  end

  wire logic wake_armed = wake_flag_ff && wake_irq_enable;
  wire logic kick_armed = kick_flag_ff && kick_irq_enable;

  // Power release: enabled wake or kick flag forces it low over any write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      power_release_ff <= 1'(`RST_FLAGS >> `BIT_POWER_RELEASE);
    end else if (wake_armed || kick_armed ||
                 (state_ff == wake_kick_pkg::PWR_WAIT && supply_valid)) begin
      power_release_ff <= 1'b0;
    end else if (flags_wr) begin
      power_release_ff <= wdata[`BIT_POWER_RELEASE];
    end
  end

  // ========================================================================
  // Power-on sequencer
  // ========================================================================
  wire logic start_evt = (wake_evt && wake_irq_enable) ||
                         (kick_evt && kick_irq_enable);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff   <= wake_kick_pkg::PWR_OFF;
      timeout_ff <= 32'h0000_0000;
    end else begin
      case (state_ff)
        wake_kick_pkg::PWR_OFF: begin
          if (start_evt && !supply_valid) begin
            state_ff   <= wake_kick_pkg::PWR_WAIT;
            timeout_ff <= 32'(POWER_ON_CYCLES);
          end else if (start_evt || (supply_valid && !power_release_ff)) begin
            state_ff <= wake_kick_pkg::PWR_ON;
          end
        end
        wake_kick_pkg::PWR_WAIT: begin
          if (supply_valid) begin
            state_ff <= wake_kick_pkg::PWR_ON;
          end else if (timeout_ff == 32'h0000_0001) begin
            state_ff <= wake_kick_pkg::PWR_OFF;
          end else begin
            timeout_ff <= timeout_ff - 32'h0000_0001;
          end
        end
        wake_kick_pkg::PWR_ON: begin
          if (power_release_ff && !start_evt) begin
            state_ff <= wake_kick_pkg::PWR_OFF;
          end else if (!supply_valid && !power_hold_in_fail) begin
            state_ff <= wake_kick_pkg::PWR_OFF;
          end
        end
        default: begin
          state_ff <= wake_kick_pkg::PWR_OFF;
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign power_request_n_o  = 1'b0;
  assign power_request_n_oe = (state_ff != wake_kick_pkg::PWR_OFF);

  // ========================================================================
  // Interrupt output
  // ========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      powered_ff <= 1'b0;
    end else begin
      powered_ff <= supply_valid;
    end
  end

  // Floats without supply, so a failed attempt never shows here
  assign irq_n_o  = 1'b0;
  assign irq_n_oe = powered_ff &&
                    (wake_armed || kick_armed || other_irq ||
                     (ram_wipe_flag_ff && ram_wipe_irq_enable));

  // ========================================================================
  // Checks
  // ========================================================================
  sequence armed_s;
    wake_armed || kick_armed;
  endsequence
  sequence release_low_s;
    !power_release_ff;
  endsequence

  release_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    armed_s |=> release_low_s)
    else $error("power release not cleared by armed flag");
  timeout_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_ff == wake_kick_pkg::PWR_WAIT && !supply_valid &&
    timeout_ff == 32'h0000_0001 |=> !power_request_n_oe)
    else $error("power request held past timeout");
  wake_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    wake_evt |=> wake_flag_ff)
    else $error("wake flag not set");
  kick_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    kick_evt |=> kick_flag_ff)
    else $error("kick flag not set");
  release_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_ff == wake_kick_pkg::PWR_ON && power_release_ff && !start_evt
    |=> !power_request_n_oe)
    else $error("power release ignored");
  irq_float_a: assert property (@(posedge ref_clk) disable iff (rst)
    !supply_valid |=> !irq_n_oe)
    else $error("irq driven without supply");
  wipe_fill_a: assert property (@(posedge ref_clk) disable iff (rst)
    wipe_evt |=> ram_wipe_flag_ff && ram_ff[0] == `RAM_ONES)
    else $error("wipe did not fill ram");
  wipe_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
    wipe_fall |=> !access_ready [*2])
    else $error("access during wipe recovery");
  wipe_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !ram_wipe_enable && !flags_wr |=> $stable(ram_wipe_flag_ff))
    else $error("wipe flag moved while disabled");
  div_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    !div_ok && !supply_valid && state_ff == wake_kick_pkg::PWR_OFF
    |=> !power_request_n_oe)
    else $error("power request outside running divider");
endmodule

`default_nettype wire

// [verification/power_supply_model.sv]
/*
 * System supply model: comes up a while after the request pin is
 * pulled while respond is set, or at once while another source powers the system.
 * Assumes the block's clock and its open-drain request enable.
 */
`timescale 1ns/10ps
`default_nettype none

module power_supply_model #(
  parameter int RISE_CYCLES = 20
) (
  input  wire logic ref_clk,
  input  wire logic request,
  input  wire logic respond,
  input  wire logic host_on,
  output logic      supply_valid
);
  int ramp_ff;

  // ==========================================================
  // Ramp count; a dead supply never rises, to hit the timeout
  always_ff @(posedge ref_clk) begin
    if (host_on || !(request && respond)) begin
      ramp_ff <= 0;
    end else begin
      ramp_ff <= ramp_ff + 1;
    end
  end

  // Supply follows the request only when told to answer
  assign supply_valid = host_on || (ramp_ff >= RISE_CYCLES);
endmodule

`default_nettype wire

// [verification/wake_kick_power_tb.sv]
/*
 * Testbench: register accesses, power-on by kick and wake, timeout,
 * flag clearing, powered events and user-RAM wipe.
 * Assumes the block, its package and the supply model.
 */
`timescale 1ns/10ps
`default_nettype none

module wake_kick_power_tb;
  logic       ref_clk = 1'h0;
  logic       rst, cs, rd, wr, kick_n, wipe_n, respond, host_on;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, cur_s, cur_m, cur_h, cur_d;
  logic [2:0] div_ctl;
  logic       osc_on, oirq;
  logic       access_ready, supply_valid, req_o, req_oe, irq_o, irq_oe;
  int         bad_count = 0;
  int         samples_checked = 0;

  // ==========================================================
  // Clock and instances
  always #5 ref_clk = ~ref_clk;

  wake_kick_power #(.POWER_ON_CYCLES(1000), .KICK_CYCLES(5),
    .RECOVERY_CYCLES(100)) DUT (
    .ref_clk(ref_clk), .rst(rst), .cs(cs), .rd(rd), .wr(wr),
    .addr(addr), .wdata(wdata), .rdata(rdata),
    .access_ready(access_ready), .bank_select(1'h1),
    .divider_control(div_ctl), .osc_running(osc_on),
    .supply_valid(supply_valid), .other_irq(oirq),
    .cur_seconds(cur_s), .cur_minutes(cur_m), .cur_hours(cur_h),
    .cur_date(cur_d), .kick_input_n(kick_n),
    .ram_wipe_input_n(wipe_n), .power_request_n_o(req_o),
    .power_request_n_oe(req_oe), .irq_n_o(irq_o), .irq_n_oe(irq_oe));

  power_supply_model SUPPLY (.ref_clk(ref_clk), .request(req_oe),
    .respond(respond), .host_on(host_on), .supply_valid(supply_valid));

  // ==========================================================
  // Helpers
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, s);
    samples_checked++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask

  // Held until ready is sampled high, released on that same edge
  task automatic access(input logic w, input logic [6:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cs <= 1'h1;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (access_ready !== 1'h1 && n < 3000);
    cs <= 1'h0;
    rd <= 1'h0;
    wr <= 1'h0;
    chk("access_ready", 8'h01, {7'h00, access_ready});
    if (n >= 3000) stop_test();
  endtask

  task automatic reg_read(input logic [6:0] a, input logic [7:0] e);
    access(1'h0, a, 8'h00);
    @(posedge ref_clk);
    #1;
    chk($sformatf("reg_%h", a), e, rdata);
  endtask

  // Waits for an output enable; too early counts as a mismatch too
  task automatic wait_sig(input logic irq, v, input int lo);
    int n;
    logic s;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      s = irq ? irq_oe : req_oe;
    end while (s !== v && n < 3000);
    chk($sformatf("oe_%0d_cycles_%0d", irq, n), {7'h00, v}, {7'h00, s});
    if (s !== v || n < lo) begin
      $display("BAD wait_%0d expected at least %0d seen %0d", irq, lo, n);
      bad_count++;
      stop_test();
    end
  endtask

  task automatic pulse(input logic wipe, input int len);
    @(posedge ref_clk);
    if (wipe) wipe_n <= 1'h0;
    else kick_n <= 1'h0;
    repeat (len) @(posedge ref_clk);
    wipe_n <= 1'h1;
    kick_n <= 1'h1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {rst, host_on, kick_n, wipe_n} = 4'hF;
    {cs, rd, wr, respond, addr, wdata} = 19'h00000;
    // Time must differ from the zeroed alarms, or reset ends in a match
    {cur_s, cur_m, cur_h, cur_d} = 32'h01000000;
    {div_ctl, osc_on, oirq} = 5'h0A;
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    reg_read(7'h4A, 8'h08);
    reg_read(7'h4B, 8'h00);
    access(1'h1, 7'h01, 8'h30);
    access(1'h1, 7'h03, 8'h15);
    access(1'h1, 7'h05, 8'h07);
    access(1'h1, 7'h49, 8'h21);
    reg_read(7'h49, 8'h21);
    access(1'h1, 7'h4B, 8'h03);
    access(1'h1, 7'h4A, 8'h08);
    host_on <= 1'h0;
    repeat (4) @(posedge ref_clk);
    pulse(1'h0, 3);
    repeat (20) @(posedge ref_clk);
    chk("short_kick", 8'h00, {7'h00, req_oe});
    // Long kicks with the divider held or the oscillator stopped
    div_ctl <= 3'h6;
    pulse(1'h0, 8);
    repeat (20) @(posedge ref_clk);
    chk("div_stopped", 8'h00, {7'h00, req_oe});
    {div_ctl, osc_on} <= 4'h4;
    pulse(1'h0, 8);
    repeat (20) @(posedge ref_clk);
    chk("osc_stopped", 8'h00, {7'h00, req_oe});
    {div_ctl, osc_on} <= 4'h7;
    pulse(1'h0, 8);
    wait_sig(1'h0, 1'h1, 0);
    wait_sig(1'h0, 1'h0, 900);
    chk("irq_dead", 8'h00, {7'h00, irq_oe});
    respond <= 1'h1;
    {cur_s, cur_m, cur_h, cur_d} <= 32'h30150721;
    wait_sig(1'h0, 1'h1, 0);
    wait_sig(1'h1, 1'h1, 0);
    reg_read(7'h4A, 8'h03);
    host_on <= 1'h1;
    cur_s <= 8'h31;
    access(1'h1, 7'h4A, 8'h00);
    wait_sig(1'h1, 1'h0, 0);
    oirq <= 1'h1;
    wait_sig(1'h1, 1'h1, 0);
    oirq <= 1'h0;
    wait_sig(1'h1, 1'h0, 0);
    chk("req_hold", 8'h01, {7'h00, req_oe});
    access(1'h1, 7'h4A, 8'h08);
    wait_sig(1'h0, 1'h0, 0);
    pulse(1'h0, 2);
    wait_sig(1'h0, 1'h1, 0);
    wait_sig(1'h1, 1'h1, 0);
    reg_read(7'h4A, 8'h01);
    access(1'h1, 7'h4A, 8'h08);
    wait_sig(1'h1, 1'h0, 0);
    access(1'h1, 7'h0F, 8'h11);
    pulse(1'h1, 5);
    reg_read(7'h0F, 8'h11);
    access(1'h1, 7'h0E, 8'h5A);
    access(1'h1, 7'h4B, 8'h17);
    pulse(1'h1, 5);
    reg_read(7'h0E, 8'hFF);
    reg_read(7'h0F, 8'hFF);
    reg_read(7'h01, 8'h30);
    // Release still 0: the armed kick flag beat the release write
    reg_read(7'h4A, 8'h04);
    wait_sig(1'h1, 1'h1, 0);
    access(1'h1, 7'h4A, 8'h08);
    wait_sig(1'h1, 1'h0, 0);
    access(1'h1, 7'h4A, 8'h0A);
    wait_sig(1'h1, 1'h1, 0);
    chk("pins_low", 8'h00, {6'h00, req_o, irq_o});
    stop_test();
  end
endmodule

`default_nettype wire
